// ### srs_reset_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Reset source combiner and stretch sequencer with APB status access
module srs_reset_sequencer
  import srs_pkg::*;
#(
  parameter int unsigned STRETCH_CYC [8] = SRS_STRETCH_CYC_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        power_on_below,
  input  wire logic        reset_pin_n,
  input  wire logic        brownout_below,
  input  wire logic        watchdog_expire,
  input  wire logic [1:0]  startup_time_select_fuse,
  input  wire logic [3:0]  clock_source_select_fuse,
  input  wire logic        reset_pin_disable_fuse,
  input  wire logic [2:0]  brownout_level_fuse,
  output logic      [2:0]  brownout_threshold,
  output logic             io_reset_n,
  output logic             core_reset_n,
  output logic             vector_start
);

  // ==========================================================================
  // Input synchronisation
  localparam srs_pins_t PINS_RST = '{power_on_below: 1'b1, reset_pin_n: 1'b1, brownout_below: 1'b0,
                                     fuse: '{startup_time_select_fuse: 2'h0, clock_source_select_fuse: 4'h0,
                                             reset_pin_disable_fuse: 1'b0, brownout_level_fuse: SRS_BOD_OFF_LVL}};

  srs_pins_t pins_raw;
  srs_pins_t pins_s;

  assign pins_raw = '{power_on_below: power_on_below, reset_pin_n: reset_pin_n,
                      brownout_below: brownout_below,
                      fuse: '{startup_time_select_fuse: startup_time_select_fuse,
                              clock_source_select_fuse: clock_source_select_fuse,
                              reset_pin_disable_fuse: reset_pin_disable_fuse,
                              brownout_level_fuse: brownout_level_fuse}};

  srs_sync #(
    .W       ($bits(srs_pins_t)),
    .RST_VAL (PINS_RST)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pins_raw),
    .q     (pins_s)
  );

  // ==========================================================================
  // Source qualification
  logic        pin_src;
  logic        bod_en;
  logic        any_src;
  logic [23:0] stretch_limit;
  logic [2:0]  stretch_sel;

  assign pin_src       = ~pins_s.reset_pin_n & ~pins_s.fuse.reset_pin_disable_fuse;
  assign bod_en        = pins_s.fuse.brownout_level_fuse != SRS_BOD_OFF_LVL;
  assign stretch_sel   = {pins_s.fuse.clock_source_select_fuse[3], pins_s.fuse.startup_time_select_fuse};
  assign stretch_limit = 24'(STRETCH_CYC[stretch_sel]);

  srs_state_t s;
  srs_state_t next_s;

  assign any_src = pins_s.power_on_below | pin_src | s.bod_qual | s.wdt_pulse;

  // ==========================================================================
  // Bus decode
  logic bus_access;
  logic bus_commit;

  assign bus_access = psel & penable & ~s.ack;
  assign bus_commit = psel & penable & s.ack;

  // ==========================================================================
  // Next state
  always_comb begin
    next_s               = s;
    next_s.release_pulse = 1'b0;
    // Watchdog expiry becomes a single-cycle reset pulse
    next_s.wdt_pulse     = watchdog_expire & s.wdt_en & ~s.wdt_pulse;
    // Brown-out filter: act only on drops longer than the minimum duration
    if (bod_en && pins_s.brownout_below) begin
      if (s.bod_cnt < 8'(SRS_BOD_MIN_CYC)) begin
        next_s.bod_cnt = s.bod_cnt + 8'h01;
      end else begin
        next_s.bod_qual = 1'b1;
      end
    end else begin
      next_s.bod_cnt  = 8'h00;
      next_s.bod_qual = 1'b0;
    end
    // Sequencer
    case (s.phase)
      SRS_HOLD: begin
        next_s.core_reset = 1'b1;
        next_s.cnt        = 24'h000000;
        if (!any_src) begin
          next_s.phase = SRS_STRETCH;
        end
      end
      SRS_STRETCH: begin
        if (any_src) begin
          next_s.phase = SRS_HOLD;
          next_s.cnt   = 24'h000000;
        end else if (s.cnt + 24'h000001 >= stretch_limit) begin
          next_s.phase         = SRS_RUN;
          next_s.core_reset    = 1'b0;
          next_s.release_pulse = 1'b1;
        end else begin
          next_s.cnt = s.cnt + 24'h000001;
        end
      end
      default: begin
        if (any_src) begin
          next_s.phase      = SRS_HOLD;
          next_s.core_reset = 1'b1;
        end
      end
    endcase
    // Software clears flags by writing zero
    if (bus_commit && pwrite && paddr == SRS_STATUS_OFF) begin
      next_s.flags = s.flags & pwdata[3:0];
    end
    if (bus_commit && pwrite && paddr == SRS_CTRL_OFF) begin
      next_s.wdt_en = pwdata[SRS_WDTEN_BIT];
    end
    // Hardware set wins over a clear in the same cycle
    if (pins_s.power_on_below) begin
      next_s.flags[SRS_PON_BIT] = 1'b1;
      next_s.flags[SRS_EXT_BIT] = 1'b0;
      next_s.flags[SRS_BOD_BIT] = 1'b0;
      next_s.flags[SRS_WDT_BIT] = 1'b0;
    end else begin
      if (pin_src) begin
        next_s.flags[SRS_EXT_BIT] = 1'b1;
      end
      if (s.bod_qual) begin
        next_s.flags[SRS_BOD_BIT] = 1'b1;
      end
      if (s.wdt_pulse) begin
        next_s.flags[SRS_WDT_BIT] = 1'b1;
      end
    end
    // APB: one wait state, read data captured in the first access cycle
    next_s.ack = bus_access;
    if (bus_access) begin
      next_s.pslverr = 1'b0;
      next_s.prdata  = 32'h00000000;
      if (paddr == SRS_STATUS_OFF) begin
        next_s.prdata = {28'h0000000, s.flags};
      end else if (paddr == SRS_CTRL_OFF) begin
        next_s.prdata = {31'h00000000, s.wdt_en};
      end else if (paddr == SRS_STATE_OFF) begin
        next_s.prdata = {27'h0000000, bod_en, s.bod_qual, s.core_reset, s.phase};
      end else if (paddr == SRS_FUSE_OFF) begin
        next_s.prdata = {22'h000000, pins_s.fuse};
      end else begin
        next_s.pslverr = 1'b1;
      end
    end
  end

  // ==========================================================================
  // State register; bus reset puts the core in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{phase: SRS_HOLD, cnt: 24'h000000, bod_cnt: 8'h00, bod_qual: 1'b0, wdt_pulse: 1'b0,
             core_reset: 1'b1, release_pulse: 1'b0, flags: SRS_FLAGS_RST, wdt_en: SRS_WDTEN_RST,
             ack: 1'b0, prdata: 32'h00000000, pslverr: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  // Port reset acts straight from the power-on and reset pins, without a clock
  assign io_reset_n         = ~(power_on_below | (~reset_pin_n & ~reset_pin_disable_fuse)
                                | s.core_reset);
  assign core_reset_n       = ~s.core_reset;
  assign vector_start       = s.release_pulse;
  assign brownout_threshold = pins_s.fuse.brownout_level_fuse;
  assign prdata             = s.prdata;
  assign pslverr            = s.pslverr & s.ack;
  assign pready             = s.ack;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pon_holds_reset_a : assert property (pins_s.power_on_below |=> s.core_reset)
    else $error("power-on source did not hold reset");
  pon_reassert_a : assert property ((s.phase == SRS_RUN && pins_s.power_on_below) |=> !core_reset_n)
    else $error("power-on drop did not reassert reset at once");
  wdt_one_cycle_a : assert property ($rose(s.wdt_pulse) |=> !s.wdt_pulse)
    else $error("watchdog pulse longer than one cycle");
  wdt_gated_a : assert property (!s.wdt_en |=> !s.wdt_pulse)
    else $error("watchdog pulse while system reset mode off");
  wdt_flag_set_a : assert property ((s.wdt_pulse && !pins_s.power_on_below) |=> s.flags[SRS_WDT_BIT])
    else $error("watchdog flag not set");
  pon_flag_set_a : assert property (pins_s.power_on_below |=> s.flags[SRS_PON_BIT])
    else $error("power-on flag not set");
  pin_ignored_a : assert property ((pins_s.fuse.reset_pin_disable_fuse && s.phase == SRS_RUN
                                   && !pins_s.power_on_below && !s.bod_qual && !s.wdt_pulse)
                                   |=> s.phase == SRS_RUN)
    else $error("disabled reset pin still caused reset");
  bod_filter_a : assert property ($rose(pins_s.brownout_below) |-> !s.bod_qual [*3])
    else $error("brown-out acted before minimum duration");
  stretch_restart_a : assert property ((s.phase == SRS_STRETCH && any_src)
                                       |=> s.phase == SRS_HOLD && s.cnt == 24'h000000)
    else $error("stretch not restarted by new source");
  release_sync_a : assert property ($fell(s.core_reset) |-> $past(s.phase) == SRS_STRETCH
                                    && s.release_pulse)
    else $error("reset released outside stretch end");

  wdt_reset_c : cover property (s.wdt_pulse ##1 s.phase == SRS_HOLD ##1 s.phase == SRS_STRETCH);
  bod_reset_c : cover property ($rose(s.bod_qual));
  release_c   : cover property ($rose(vector_start));
  restart_c   : cover property (s.phase == SRS_STRETCH ##1 s.phase == SRS_HOLD);

endmodule
`default_nettype wire

// ### srs_pkg.sv
package srs_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] SRS_STATUS_OFF = 8'h00;
  localparam logic [7:0] SRS_CTRL_OFF   = 8'h04;
  localparam logic [7:0] SRS_STATE_OFF  = 8'h08;
  localparam logic [7:0] SRS_FUSE_OFF   = 8'h0c;
  localparam int         SRS_PON_BIT    = 0;
  localparam int         SRS_EXT_BIT    = 1;
  localparam int         SRS_BOD_BIT    = 2;
  localparam int         SRS_WDT_BIT    = 3;
  localparam int         SRS_WDTEN_BIT  = 0;
  localparam logic [3:0] SRS_FLAGS_RST  = 4'h0;
  localparam logic       SRS_WDTEN_RST  = 1'b0;
  localparam logic [2:0] SRS_BOD_OFF_LVL = 3'h7;

  // ==========================================================================
  // Timing
  localparam int unsigned SRS_CLK_NS      = 20;
  localparam int unsigned SRS_BOD_MIN_NS  = 2000;
  localparam int unsigned SRS_BOD_MIN_CYC = (SRS_BOD_MIN_NS + SRS_CLK_NS - 1) / SRS_CLK_NS;
  localparam int unsigned SRS_STRETCH_NS [8] = '{20, 4100000, 4100000, 65000000,
                                                  20, 20, 4100000, 65000000};
  localparam int unsigned SRS_STRETCH_CYC_DEF [8] = '{
    SRS_STRETCH_NS[0] / SRS_CLK_NS, SRS_STRETCH_NS[1] / SRS_CLK_NS,
    SRS_STRETCH_NS[2] / SRS_CLK_NS, SRS_STRETCH_NS[3] / SRS_CLK_NS,
    SRS_STRETCH_NS[4] / SRS_CLK_NS, SRS_STRETCH_NS[5] / SRS_CLK_NS,
    SRS_STRETCH_NS[6] / SRS_CLK_NS, SRS_STRETCH_NS[7] / SRS_CLK_NS};

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {SRS_HOLD, SRS_STRETCH, SRS_RUN} srs_phase_t;

  typedef struct packed {
    logic [1:0] startup_time_select_fuse;
    logic [3:0] clock_source_select_fuse;
    logic       reset_pin_disable_fuse;
    logic [2:0] brownout_level_fuse;
  } srs_fuse_t;

  typedef struct packed {
    logic      power_on_below;
    logic      reset_pin_n;
    logic      brownout_below;
    srs_fuse_t fuse;
  } srs_pins_t;

  typedef struct packed {
    srs_phase_t  phase;
    logic [23:0] cnt;
    logic [7:0]  bod_cnt;
    logic        bod_qual;
    logic        wdt_pulse;
    logic        core_reset;
    logic        release_pulse;
    logic [3:0]  flags;
    logic        wdt_en;
    logic        ack;
    logic [31:0] prdata;
    logic        pslverr;
  } srs_state_t;

endpackage

// ### srs_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Two-stage synchroniser for asynchronous pins and fuses
module srs_sync #(
  parameter int                 W       = 1,
  parameter logic [W-1:0]       RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } srs_sync_t;

  srs_sync_t s;
  srs_sync_t next_s;

  // Shift one stage per clock
  always_comb begin
    next_s.ff1 = d;
    next_s.ff2 = s.ff1;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= {RST_VAL, RST_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.ff2;

endmodule
`default_nettype wire

// ### srs_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Supply monitors, reset pin and watchdog as seen by the sequencer
module srs_far_model (
  input  wire logic pclk,
  output logic      power_on_below,
  output logic      reset_pin_n,
  output logic      brownout_below,
  output logic      watchdog_expire
);
  // Supply starts below threshold, pin released, detectors quiet
  initial begin
    power_on_below  = 1'b1;
    reset_pin_n     = 1'b1;
    brownout_below  = 1'b0;
    watchdog_expire = 1'b0;
  end

  // Set one source active or inactive: 0 power-on, 1 pin, 2 brown-out
  task automatic drive(input int sel, input logic act);
    case (sel)
      0:       power_on_below <= act;
      1:       reset_pin_n    <= ~act;
      default: brownout_below <= act;
    endcase
  endtask

  // Hold a source active for n cycles, then release it
  task automatic hold_source(input int sel, input int n);
    @(posedge pclk);
    drive(sel, 1'b1);
    repeat (n) @(posedge pclk);
    drive(sel, 1'b0);
  endtask

  // Watchdog expiry is a single-cycle pulse
  task automatic fire_watchdog();
    @(posedge pclk);
    watchdog_expire <= 1'b1;
    @(posedge pclk);
    watchdog_expire <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb_system_reset_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Self-checking bench for the reset sequencer
module tb_system_reset_sequencer;
  import srs_pkg::*;
  localparam int unsigned SIM_CYC [8] = '{4, 5, 6, 7, 8, 9, 10, 11};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, low_seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        power_on_below, reset_pin_n, brownout_below, watchdog_expire;
  logic [1:0]  startup_time_select_fuse;
  logic [3:0]  clock_source_select_fuse;
  logic        reset_pin_disable_fuse;
  logic [2:0]  brownout_level_fuse, brownout_threshold;
  logic        io_reset_n, core_reset_n, vector_start;
  int          fails, check_count, base, lat, k;

  srs_reset_sequencer #(.STRETCH_CYC(SIM_CYC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_below(power_on_below), .reset_pin_n(reset_pin_n),
    .brownout_below(brownout_below), .watchdog_expire(watchdog_expire),
    .startup_time_select_fuse(startup_time_select_fuse),
    .clock_source_select_fuse(clock_source_select_fuse),
    .reset_pin_disable_fuse(reset_pin_disable_fuse), .brownout_level_fuse(brownout_level_fuse),
    .brownout_threshold(brownout_threshold), .io_reset_n(io_reset_n),
    .core_reset_n(core_reset_n), .vector_start(vector_start));

  srs_far_model u_far (
    .pclk(pclk), .power_on_below(power_on_below), .reset_pin_n(reset_pin_n),
    .brownout_below(brownout_below), .watchdog_expire(watchdog_expire));

  // 50 MHz clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  // Remember any core reset seen since the last clear
  always @(negedge pclk) if (core_reset_n === 1'b0) low_seen <= 1'b1;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  // Outputs are looked at mid-cycle, where they are settled; the request is released at the next rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask

  // Count cycles until the core leaves reset; start pulse comes with it, for one cycle
  task automatic wait_release(output int n);
    n = 0;
    while (core_reset_n !== 1'b1 && n < 300) begin
      @(negedge pclk);
      n++;
    end
    if (core_reset_n !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    chk("vector_start_on", vector_start, 1'b1);
    @(negedge pclk);
    chk("vector_start_off", vector_start, 1'b0);
    @(posedge pclk);
  endtask

  // Hold a source active for n cycles, release it, then check the core stayed out of reset
  task automatic expect_quiet(input int sel, input int n, input string name);
    low_seen <= 1'b0;
    u_far.hold_source(sel, n);
    repeat (4) @(posedge pclk);
    chk(name, low_seen, 1'b0);
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    startup_time_select_fuse = 2'h0; clock_source_select_fuse = 4'h0;
    reset_pin_disable_fuse = 1'b0; brownout_level_fuse = 3'h7;
    fails = 0; check_count = 0; low_seen = 1'b0;
    k = $urandom(9);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("io_reset_pon", io_reset_n, 1'b0);
    rd_chk(SRS_CTRL_OFF, 32'h0, "ctrl_reset");
    u_far.drive(0, 1'b0);
    wait_release(base);
    rd_chk(SRS_STATUS_OFF, 32'h1, "status_pon");
    apb(1'b1, SRS_STATUS_OFF, 32'h0);
    rd_chk(SRS_STATUS_OFF, 32'h0, "status_clear");
    // Every stretch selection with a random pin pulse
    for (int i = 0; i < 8; i++) begin
      startup_time_select_fuse <= i[1:0];
      clock_source_select_fuse <= {i[2], 3'b000};
      repeat (4) @(posedge pclk);
      u_far.hold_source(1, 6 + $urandom_range(6));
      wait_release(lat);
      if (i == 0) base = lat;
      chk("stretch_len", lat - base, SIM_CYC[i] - SIM_CYC[0]);
    end
    rd_chk(SRS_STATUS_OFF, 32'h2, "status_ext");
    startup_time_select_fuse <= 2'h0;
    clock_source_select_fuse <= 4'h0;
    repeat (4) @(posedge pclk);
    // Second pin pulse inside the stretch restarts it
    u_far.hold_source(1, 8);
    repeat (3) @(posedge pclk);
    u_far.hold_source(1, 8);
    wait_release(lat);
    chk("restart_len", lat, base);
    @(posedge pclk);
    u_far.drive(0, 1'b1);
    #1 chk("io_reset_drop", io_reset_n, 1'b0);
    repeat (5) @(posedge pclk);
    u_far.drive(0, 1'b0);
    wait_release(lat);
    rd_chk(SRS_STATUS_OFF, 32'h1, "status_pon2");
    apb(1'b1, SRS_STATUS_OFF, 32'h0);
    reset_pin_disable_fuse <= 1'b1;
    repeat (4) @(posedge pclk);
    expect_quiet(1, 20, "pin_disabled");
    reset_pin_disable_fuse <= 1'b0;
    apb(1'b1, SRS_CTRL_OFF, 32'h0);
    low_seen <= 1'b0;
    u_far.fire_watchdog();
    repeat (8) @(posedge pclk);
    chk("wdt_masked", low_seen, 1'b0);
    apb(1'b1, SRS_CTRL_OFF, 32'h1);
    u_far.fire_watchdog();
    k = 0;
    while (core_reset_n !== 1'b0 && k < 10) begin
      @(negedge pclk);
      k++;
    end
    chk("wdt_reset", core_reset_n, 1'b0);
    wait_release(lat);
    rd_chk(SRS_STATUS_OFF, 32'h8, "status_wdt");
    apb(1'b1, SRS_STATUS_OFF, 32'h0);
    apb(1'b1, SRS_CTRL_OFF, 32'h0);
    expect_quiet(2, 150, "bod_disabled");
    brownout_level_fuse <= 3'h3;
    repeat (4) @(posedge pclk);
    chk("bod_level", brownout_threshold, 3'h3);
    expect_quiet(2, 20 + $urandom_range(70), "bod_short");
    expect_quiet(2, 100, "bod_edge");
    u_far.hold_source(2, 130);
    chk("bod_reset", core_reset_n, 1'b0);
    wait_release(lat);
    rd_chk(SRS_STATUS_OFF, 32'h4, "status_bod");
    apb(1'b1, 8'h10, $urandom);
    chk("unmapped_err", err, 1'b1);
    apb(1'b1, SRS_FUSE_OFF, 32'h3ff);
    rd_chk(SRS_FUSE_OFF, 32'h3, "fuse_ro");
    tally_and_finish();
  end
endmodule
`default_nettype wire
